// [shared/pil_pkg.sv]
// package: constants, modes and carriers for the panel indicator logic
`default_nettype none
package pil_pkg;
    // clock and shared timebase
    localparam int CLK_MHZ = 100;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    localparam int FLASH_HALF = TICKS_PER_S / 2;
    // timed periods in seconds, as counted by the one second tick
    localparam int GATE_S = 45;
    localparam int WDOG_WIN_S = 10;
    localparam int POWERUP_S = 30;
    localparam int INHIBIT_S = 3600;
    // polled lamp stays lit this many ticks per poll
    localparam int POLL_TICKS = 2;
    // watchdog restart failures that latch the lamp
    localparam int WDOG_FAILS = 2;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FIRE_ZONE_OFS = 8'h04;
    localparam logic [7:0] TRACK_OFS = 8'h08;
    localparam logic [7:0] LAMPS_OFS = 8'h0c;
    localparam logic [7:0] ZONE_LAMPS_OFS = 8'h10;
    localparam logic [7:0] ZONE_LATCH_OFS = 8'h14;
    localparam logic [7:0] STATE_OFS = 8'h18;
    // control fields
    localparam int CTRL_LAMP_TEST_BIT = 0;
    localparam int CTRL_REMOTE_BIT = 1;
    localparam int CTRL_RESET_BIT = 2;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] FIRE_ZONE_RST = 16'hffff;
    localparam logic [15:0] TRACK_RST = 16'h0000;
    // lamp behaviours, lowest priority first up to steady; pick ranks rapid above irapid
    typedef enum logic [2:0] {
        MODE_OFF, MODE_FLASH, MODE_STEADY, MODE_RAPID, MODE_IRAPID
    } pil_mode_t;
    // condition inputs from the surrounding alarm logic
    typedef struct packed {
        logic [1:0] silence_master;
        logic silence_remote;
        logic cpu_running;
        logic wdog_bite;
        logic [4:0] loop_fault;
        logic foreign_resp;
        logic comms_ok;
        logic poll;
        logic rmt_defect;
        logic link_defect;
        logic foreign_rmt;
        logic ext_defect_n;
        logic display_fault;
        logic battery_low_lamp;
        logic chg_start;
        logic [4:0] evac_fault;
        logic arr_fault;
        logic st_running;
        logic st_passed;
        logic st_failed;
        logic reinit;
        logic no_resp;
        logic nvm_fatal;
    } pil_cond_t;
    // lamp drives, high lights the lamp
    typedef struct packed {
        logic silence;
        logic common_fire;
        logic non_fire;
        logic watchdog;
        logic loop;
        logic polled;
        logic remote_def;
        logic evac;
        logic batt;
        logic charger;
        logic self_test;
        logic fault;
    } pil_lamp_t;
endpackage
`default_nettype wire

// [core/pil_panel_indicator.sv]
// panel indicator logic: lamp patterns, history latches, ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module pil_panel_indicator #(
    parameter int TICK_CYCLES = pil_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // conditions from the alarm logic
    input wire pil_pkg::pil_cond_t cond,
    input wire logic [15:0] zone_alarm,
    input wire logic [15:0] zone_gated,
    input wire logic [15:0] zone_defect,
    input wire logic [15:0] zone_test_fail,
    input wire logic door_open,
    // lamps and controller outputs
    output pil_pkg::pil_lamp_t lamps,
    output logic [15:0] zone_alarm_lamp,
    output logic [15:0] zone_defect_lamp,
    output logic defect_force,
    output logic buzzer_on
);
    // register state
    logic [1:0] ctrl_q;
    logic [15:0] fire_zone_q;
    logic [15:0] track_q;
    logic panel_reset;
    logic lamp_test;
    logic remote;
    assign lamp_test = ctrl_q[pil_pkg::CTRL_LAMP_TEST_BIT];
    assign remote = ctrl_q[pil_pkg::CTRL_REMOTE_BIT];

    // shared timebase: cycle prescaler, tick phase and one second tick
    logic [31:0] pre_q;
    logic [3:0] phase_q;
    logic tick;
    logic sec;
    logic ph_flash;
    logic ph_rapid;
    logic ph_irapid;
    assign tick = (pre_q == 32'(TICK_CYCLES - 1));
    assign sec = tick && (phase_q == 4'(pil_pkg::TICKS_PER_S - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 32'h0;
            phase_q <= 4'h0;
        end else begin
            pre_q <= tick ? 32'h0 : pre_q + 32'h1;
            if (sec) begin
                phase_q <= 4'h0;
            end else if (tick) begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end
    // all lamps share these phases so they flash in step
    assign ph_flash = (phase_q < 4'(pil_pkg::FLASH_HALF));
    assign ph_rapid = phase_q[0];
    assign ph_irapid = ph_rapid & ph_flash;

    // highest requested behaviour wins
    function automatic pil_pkg::pil_mode_t pick(input logic irap,
            input logic rap, input logic stdy, input logic fl);
        if (rap) begin
            pick = pil_pkg::MODE_RAPID;
        end else if (irap) begin
            pick = pil_pkg::MODE_IRAPID;
        end else if (stdy) begin
            pick = pil_pkg::MODE_STEADY;
        end else if (fl) begin
            pick = pil_pkg::MODE_FLASH;
        end else begin
            pick = pil_pkg::MODE_OFF;
        end
    endfunction

    // turn a behaviour into a lamp level; door blanking and lamp test
    function automatic logic show(input pil_pkg::pil_mode_t m,
            input logic blank, input logic lt, input logic f,
            input logic r, input logic ir);
        logic v;
        v = 1'b0;
        case (m)
            pil_pkg::MODE_FLASH: v = f;
            pil_pkg::MODE_STEADY: v = 1'b1;
            pil_pkg::MODE_RAPID: v = r;
            pil_pkg::MODE_IRAPID: v = ir;
            default: v = 1'b0;
        endcase
        show = lt | (v & ~blank);
    endfunction

    logic blank;
    assign blank = ~door_open;

    // per zone gating timer, alarm and defect history
    logic [15:0] zalarm_q;
    logic [15:0] zdef_q;
    logic [15:0] zact;
    logic [15:0] za_mode;
    logic [15:0] zd_mode;
    genvar z;
    generate
        for (z = 0; z < 16; z++) begin : g_zone
            logic [5:0] gate_q;
            logic gated_d1_q;
            logic gate_run;
            assign gate_run = (gate_q != 6'h0);
            // gated smoke counts only inside its gating window
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    gate_q <= 6'h0;
                    gated_d1_q <= 1'b0;
                end else begin
                    gated_d1_q <= zone_gated[z];
                    if (zone_gated[z] && !gated_d1_q) begin
                        gate_q <= 6'(pil_pkg::GATE_S);
                    end else if (sec && gate_run) begin
                        gate_q <= gate_q - 6'h1;
                    end
                end
            end
            assign zact[z] = zone_alarm[z] | (zone_gated[z] & gate_run);
            // set wins over panel reset; tracking zones never latch an alarm, but defects still latch
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    zalarm_q[z] <= 1'b0;
                    zdef_q[z] <= 1'b0;
                end else begin
                    zalarm_q[z] <= (zact[z] & ~track_q[z]) |
                        (zalarm_q[z] & ~panel_reset);
                    zdef_q[z] <= zone_defect[z] |
                        (zdef_q[z] & ~panel_reset);
                end
            end
            assign za_mode[z] = zact[z] | zalarm_q[z];
            assign zd_mode[z] = zone_defect[z] | zdef_q[z] |
                zone_test_fail[z];
        end
    endgenerate

    // common fire and non-fire by zone class
    logic any_fire;
    logic any_nonfire;
    assign any_fire = |(za_mode & fire_zone_q);
    assign any_nonfire = |(za_mode & ~fire_zone_q);

    // watchdog: count bites inside the window after the first one
    logic [3:0] wwin_q;
    logic [1:0] wcnt_q;
    logic wdog_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wwin_q <= 4'h0;
            wcnt_q <= 2'h0;
        end else if (cond.wdog_bite) begin
            if (wwin_q == 4'h0) begin
                wwin_q <= 4'(pil_pkg::WDOG_WIN_S);
                wcnt_q <= 2'h0;
            end else if (wcnt_q != 2'h3) begin
                wcnt_q <= wcnt_q + 2'h1;
            end
        end else if (sec && wwin_q != 4'h0) begin
            wwin_q <= wwin_q - 4'h1;
        end
    end
    // the latch is history; a new failure wins over panel reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_q <= 1'b0;
        end else begin
            wdog_q <= (cond.wdog_bite && wwin_q != 4'h0 &&
                wcnt_q == 2'(pil_pkg::WDOG_FAILS - 1)) |
                (wdog_q & ~panel_reset);
        end
    end

    // loop defect history and power-up rapid window
    logic loop_q;
    logic [4:0] pwr_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_q <= 1'b0;
            pwr_q <= 5'(pil_pkg::POWERUP_S);
        end else begin
            loop_q <= (|cond.loop_fault) | (loop_q & ~panel_reset);
            // ends early once responders all answer
            if (cond.comms_ok) begin
                pwr_q <= 5'h0;
            end else if (sec && pwr_q != 5'h0) begin
                pwr_q <= pwr_q - 5'h1;
            end
        end
    end

    // polled pulse, stretched so a single poll is visible
    logic [1:0] poll_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            poll_q <= 2'h0;
        end else if (remote && cond.poll) begin
            poll_q <= 2'(pil_pkg::POLL_TICKS);
        end else if (tick && poll_q != 2'h0) begin
            poll_q <= poll_q - 2'h1;
        end
    end

    // battery low history and charger inhibit period
    logic batt_q;
    logic [11:0] inh_q;
    logic dip_q;
    logic inh_run;
    assign inh_run = (inh_q != 12'h0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            batt_q <= 1'b0;
        end else begin
            batt_q <= cond.battery_low_lamp | (batt_q & ~panel_reset);
        end
    end
    // panel reset clears the inhibit timer and forgets the dip, unless chg_start comes in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inh_q <= 12'h0;
            dip_q <= 1'b0;
        end else if (cond.chg_start) begin
            inh_q <= 12'(pil_pkg::INHIBIT_S);
            dip_q <= cond.battery_low_lamp;
        end else if (panel_reset) begin
            inh_q <= 12'h0;
            dip_q <= 1'b0;
        end else begin
            if (sec && inh_run) begin
                inh_q <= inh_q - 12'h1;
            end
            // dip holds for the rest of the period
            dip_q <= inh_run & (dip_q | cond.battery_low_lamp);
        end
    end

    // behaviour of each lamp
    pil_pkg::pil_mode_t m_sil, m_loop, m_rdef, m_evac, m_batt;
    pil_pkg::pil_mode_t m_chg, m_st, m_fault, m_poll;
    logic rdef_remote;
    assign rdef_remote = ~cond.ext_defect_n | cond.display_fault |
        cond.battery_low_lamp | dip_q;
    always_comb begin
        m_sil = pick(1'b0, 1'b0, cond.silence_remote,
            |cond.silence_master);
        m_loop = pick(1'b0, pwr_q != 5'h0, cond.foreign_resp,
            (|cond.loop_fault) | loop_q);
        m_rdef = remote ? pick(1'b0, 1'b0, 1'b0, rdef_remote) :
            pick(1'b0, 1'b0, cond.foreign_rmt,
            cond.rmt_defect | cond.link_defect);
        m_evac = pick(1'b0, 1'b0, cond.arr_fault,
            |cond.evac_fault);
        m_batt = pick(1'b0, 1'b0, 1'b0, cond.battery_low_lamp | batt_q);
        m_chg = pick(1'b0, 1'b0, inh_run & ~dip_q, dip_q);
        m_st = pick(cond.st_failed, cond.reinit, cond.st_passed,
            cond.st_running);
        m_fault = remote ? pick(1'b0, 1'b0, cond.display_fault, 1'b0) :
            pick(1'b0, cond.nvm_fatal, cond.display_fault,
            cond.no_resp);
        m_poll = pick(1'b0, 1'b0, remote && poll_q != 2'h0, 1'b0);
    end

    // lamp drive flops; zone alarm lamps ignore the door
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lamps <= '0;
            zone_alarm_lamp <= 16'h0000;
            zone_defect_lamp <= 16'h0000;
            defect_force <= 1'b0;
            buzzer_on <= 1'b0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                zone_alarm_lamp[i] <= lamp_test |
                    (za_mode[i] & ph_flash);
                zone_defect_lamp[i] <= lamp_test |
                    (zd_mode[i] & ph_flash & ~blank);
            end
            lamps.silence <= show(m_sil, 1'b0, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.common_fire <= lamp_test | (any_fire & ph_flash);
            lamps.non_fire <= lamp_test | (any_nonfire & ph_flash);
            lamps.watchdog <= wdog_q;
            lamps.loop <= show(m_loop, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.polled <= show(m_poll, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.remote_def <= show(m_rdef, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.evac <= show(m_evac, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.batt <= show(m_batt, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.charger <= show(m_chg, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.self_test <= show(m_st, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            lamps.fault <= show(m_fault, blank, lamp_test, ph_flash,
                ph_rapid, ph_irapid);
            // a stalled processor cannot be trusted to raise defect
            defect_force <= ~cond.cpu_running | dip_q;
            buzzer_on <= ~cond.cpu_running;
        end
    end

    // ahb-lite: address phase captured, data phase acts, no wait states
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic acc;
    assign acc = hsel && hready && htrans[1] && (hsize == 3'h2);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end
    // panel reset is a one-cycle pulse from a control write
    assign panel_reset = wr_pend_q && (wr_addr_q == pil_pkg::CTRL_OFS) &&
        hwdata[pil_pkg::CTRL_RESET_BIT];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= pil_pkg::CTRL_RST;
            fire_zone_q <= pil_pkg::FIRE_ZONE_RST;
            track_q <= pil_pkg::TRACK_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                pil_pkg::CTRL_OFS: ctrl_q <= hwdata[1:0];
                pil_pkg::FIRE_ZONE_OFS: fire_zone_q <= hwdata[15:0];
                pil_pkg::TRACK_OFS: track_q <= hwdata[15:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end
    // read data is fetched in the address phase so it stands in a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                pil_pkg::CTRL_OFS: hrdata <= {30'h0, ctrl_q};
                pil_pkg::FIRE_ZONE_OFS: hrdata <= {16'h0, fire_zone_q};
                pil_pkg::TRACK_OFS: hrdata <= {16'h0, track_q};
                pil_pkg::LAMPS_OFS: hrdata <= {20'h0, lamps};
                pil_pkg::ZONE_LAMPS_OFS:
                    hrdata <= {zone_defect_lamp, zone_alarm_lamp};
                pil_pkg::ZONE_LATCH_OFS: hrdata <= {zdef_q, zalarm_q};
                pil_pkg::STATE_OFS: hrdata <= {26'h0, pwr_q != 5'h0,
                    loop_q, dip_q, inh_run, batt_q, wdog_q};
                default: hrdata <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// [verification/pil_panel_indicator_properties.sv]
// checker: timing relations at the panel indicator ports
`timescale 1ns/1ps
`default_nettype none
module pil_panel_indicator_chk (
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // conditions and lamps
    input wire pil_pkg::pil_cond_t cond,
    input wire logic door_open,
    input wire pil_pkg::pil_lamp_t lamps,
    input wire logic [15:0] zone_alarm,
    input wire logic [15:0] zone_alarm_lamp,
    input wire logic [15:0] zone_defect_lamp,
    input wire logic defect_force,
    input wire logic buzzer_on
);
    logic wp_q;
    logic lt_q;
    // mirror of the lamp test bit, so blanking checks know when to hold off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q <= 1'b0;
            lt_q <= 1'b0;
        end else if (hready) begin
            wp_q <= hsel && htrans[1] && hwrite && hsize == 3'h2
                && haddr[7:0] == pil_pkg::CTRL_OFS;
            if (wp_q) begin
                lt_q <= hwdata[0];
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_sil_flash;
        cond.silence_master != 2'h0 && !cond.silence_remote && !lt_q;
    endsequence
    sequence s_shut;
        !door_open && !lt_q;
    endsequence
    a_sil_steady: assert property (
        cond.silence_remote |=> lamps.silence)
        else $error("silence lamp not steady");
    a_sil_off: assert property (
        !cond.silence_remote && cond.silence_master == 2'h0 && !lt_q
        |=> !lamps.silence) else $error("silence lamp lit unasked");
    a_flash_step: assert property (
        s_sil_flash ##0 zone_alarm[0]
        |=> lamps.silence == zone_alarm_lamp[0])
        else $error("flash patterns out of step");
    a_batt_step: assert property (
        s_sil_flash ##0 (door_open && cond.battery_low_lamp)
        |=> lamps.batt == lamps.silence) else $error("battery flash wrong");
    a_lamp_test: assert property (
        lt_q |=> lamps.silence && lamps.loop && lamps.fault && lamps.batt
        && &zone_alarm_lamp && &zone_defect_lamp)
        else $error("lamp test not lit");
    a_door_blank: assert property (
        s_shut |=> zone_defect_lamp == 16'h0 && lamps[7:0] == 8'h0)
        else $error("lamp lit with door shut");
    a_cpu_stop: assert property (
        !cond.cpu_running |=> buzzer_on && defect_force)
        else $error("stopped processor not flagged");
    a_wdog_cause: assert property (
        $rose(lamps.watchdog)
        |-> $past(cond.wdog_bite) || $past(cond.wdog_bite, 2))
        else $error("watchdog lamp without bite");
endmodule
bind pil_panel_indicator pil_panel_indicator_chk u_chk (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .cond,
    .door_open, .lamps, .zone_alarm, .zone_alarm_lamp, .zone_defect_lamp,
    .defect_force, .buzzer_on);
`default_nettype wire

// [verification/pil_lamp_panel.sv]
// lamp panel model: counts lit cycles and turn-ons of one lamp
`timescale 1ns/1ps
`default_nettype none
module pil_lamp_panel (
    // clock
    input wire logic clk,
    // watched lamp drive
    input wire logic lit,
    // what an observer of the lamp would see
    output int on_count,
    output int turn_ons
);
    logic was_q;
    // an unknown drive is taken as dark, so it never passes for lit
    initial begin
        on_count = 0;
        turn_ons = 0;
        was_q = 1'b0;
        forever begin
            @(posedge clk);
            if (lit === 1'b1) on_count++;
            if (lit === 1'b1 && !was_q) turn_ons++;
            was_q = (lit === 1'b1);
        end
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// testbench: bus, condition and lamp scenarios for the panel indicator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam int TC = 4;
    localparam int WIN = 80; // two seconds of ticks at TC
    logic hclk, hresetn, hsel, hwrite, door_open;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, defect_force, buzzer_on;
    logic [15:0] za, zg, zd, zt, zal, zdl;
    pil_pkg::pil_cond_t cond, base;
    pil_pkg::pil_lamp_t lamps;
    logic [5:0] sel;
    int err_total, cmp_count, on0, on1, ev0, ev1, pc, pt, z, i, off;
    int cb[27] = '{30,31,29,22,23,24,25,26,21,18,17,16,7,8,9,10,11,6,13,
        5,4,3,2,14,1,0,12};
    int cp[27] = '{11,11,11,7,7,7,7,7,7,5,5,5,4,4,4,4,4,4,3,1,1,1,1,0,0,0,2};
    int ce[27] = '{40,40,80,40,40,40,40,40,80,40,40,80,40,40,40,40,40,80,
        40,40,80,16,40,80,40,40,80};
    wire logic [44:0] all_l = {buzzer_on, zdl, zal, lamps};
    pil_panel_indicator #(.TICK_CYCLES(TC)) uut (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .cond, .zone_alarm(za),
        .zone_gated(zg), .zone_defect(zd), .zone_test_fail(zt), .door_open,
        .lamps, .zone_alarm_lamp(zal), .zone_defect_lamp(zdl),
        .defect_force, .buzzer_on);
    pil_lamp_panel lp (.clk(hclk), .lit(all_l[sel]), .on_count(pc),
        .turn_ons(pt));
    // single word transfer; waits on hready, no assumed latency
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // lit cycles of one probe over a whole number of flash periods
    task automatic meas(input int p);
        sel <= p[5:0];
        repeat (3) @(posedge hclk);
        #1;
        on1 = pc;
        ev1 = pt;
        repeat (WIN) @(posedge hclk);
        #1;
        on0 = pc - on1;
        ev0 = pt - ev1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // hang guard, well beyond the planned run
    initial begin
        #500000;
        err_total++;
        summarize();
    end
    initial begin
        base = '0;
        base.cpu_running = 1'b1;
        base.ext_defect_n = 1'b1;
        cond = base;
        base.comms_ok = 1'b1;
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        {za, zg, zd, zt, sel} = '0;
        door_open = 1'b1;
        err_total = 0;
        cmp_count = 0;
        void'($urandom(69995));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        meas(7);
        `CHK("powerup loop", 40, on0)
        `CHK("powerup rapid", 10, ev0)
        @(posedge hclk);
        cond <= base;
        meas(7);
        `CHK("loop settled", 0, on0)
        // register defaults, unmapped place, write and read back
        ahb(1'b0, pil_pkg::CTRL_OFS, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        ahb(1'b0, pil_pkg::FIRE_ZONE_OFS, 32'h0);
        `CHK("fire zones", 32'h0000ffff, rd)
        ahb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("hresp", 1'b0, hresp)
        on1 = $urandom;
        ahb(1'b1, pil_pkg::TRACK_OFS, on1);
        ahb(1'b0, pil_pkg::TRACK_OFS, 32'h0);
        `CHK("tracking", {16'h0, on1[15:0]}, rd)
        ahb(1'b1, pil_pkg::TRACK_OFS, 32'h0);
        // lamp test with the door shut
        door_open <= 1'b0;
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h1);
        ahb(1'b0, pil_pkg::LAMPS_OFS, 32'h0);
        `CHK("lamp test", 32'h8ff, rd & 32'h8ff)
        ahb(1'b0, pil_pkg::ZONE_LAMPS_OFS, 32'h0);
        `CHK("lamp test zones", 32'hffffffff, rd)
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h0);
        door_open <= 1'b1;
        // one condition at a time, random starting point in the table
        off = $urandom % 27;
        for (int j = 0; j < 27; j++) begin
            i = (j + off) % 27;
            @(posedge hclk);
            cond <= base | (32'h1 << cb[i]);
            za <= 16'h1;
            meas(cp[i]);
            `CHK("lamp", ce[i], on0)
            if (cp[i] != 11) begin
                @(posedge hclk);
                door_open <= 1'b0;
                meas(cp[i]);
                `CHK("door shut", 0, on0)
            end
            @(posedge hclk);
            cond <= base;
            door_open <= 1'b1;
            ahb(1'b1, pil_pkg::CTRL_OFS, 32'h4);
            meas(cp[i]);
            `CHK("after reset", 0, on0)
        end
        @(posedge hclk);
        cond <= base | 32'h0060_0028;
        za <= 16'h0;
        meas(7);
        `CHK("steady over flash", 80, on0)
        meas(1);
        `CHK("interrupted over flash", 16, on0)
        @(posedge hclk);
        cond <= base;
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h4);
        // one random zone: non-fire, latch, tracking with gating
        z = $urandom % 16;
        ahb(1'b1, pil_pkg::FIRE_ZONE_OFS, ~(32'h1 << z) & 32'hffff);
        za[z] <= 1'b1;
        meas(9);
        `CHK("non-fire", 40, on0)
        meas(10);
        `CHK("fire", 0, on0)
        @(posedge hclk);
        za <= 16'h0;
        meas(12 + z);
        `CHK("zone latch", 40, on0)
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h4);
        meas(12 + z);
        `CHK("zone cleared", 0, on0)
        ahb(1'b1, pil_pkg::TRACK_OFS, 32'h1 << z);
        zg[z] <= 1'b1;
        meas(12 + z);
        `CHK("gated alarm", 40, on0)
        repeat (1800) @(posedge hclk);
        meas(12 + z);
        `CHK("gate lapsed", 0, on0)
        @(posedge hclk);
        zg <= 16'h0;
        zd[z] <= 1'b1;
        repeat (3) @(posedge hclk);
        zd <= 16'h0;
        meas(28 + z);
        `CHK("zone defect latch", 40, on0)
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h4);
        zt[z] <= 1'b1;
        meas(28 + z);
        `CHK("test-fire fail", 40, on0)
        @(posedge hclk);
        zt <= 16'h0;
        cond <= base | 32'h4000_3000;
        repeat (30) @(posedge hclk);
        cond <= base;
        meas(3);
        `CHK("battery latch", 40, on0)
        meas(2);
        `CHK("charger dip", 40, on0)
        `CHK("dip defect", 1'b1, defect_force)
        // remote unit mode: external defect and one poll
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h6);
        cond <= base & ~32'h8000;
        meas(5);
        `CHK("remote defect", 40, on0)
        sel <= 6'h6;
        @(posedge hclk);
        cond <= base | (32'h1 << 19);
        off = pt;
        @(posedge hclk);
        cond <= base;
        meas(6);
        `CHK("poll pulses", 1, pt - off)
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h4);
        // watchdog: first window lapses, then three bites inside one
        for (int k = 0; k < 4; k++) begin
            @(posedge hclk);
            cond <= base | (32'h1 << 27);
            @(posedge hclk);
            cond <= base;
            repeat ((k == 0) ? 440 : 40) @(posedge hclk);
            meas(8);
            `CHK("watchdog", (k == 3) ? 80 : 0, on0)
        end
        @(posedge hclk);
        cond <= base & ~(32'h1 << 28);
        meas(44);
        `CHK("buzzer", 80, on0)
        `CHK("defect force", 1'b1, defect_force)
        @(posedge hclk);
        cond <= base;
        ahb(1'b1, pil_pkg::CTRL_OFS, 32'h5);
        meas(8);
        `CHK("watchdog in lamp test", 0, on0)
        summarize();
    end
endmodule
`default_nettype wire
